// ===== core/cgc_gate_regs.sv
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "cgc_defines.svh"

module cgc_gate_regs #(
  parameter int ADDR_W = 12
)(
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic [ADDR_W-1:0]         addr,
  input  wire logic [`CGC_DATA_W-1:0]    wdata,
  input  wire logic                      wr_en,
  input  wire logic                      rd_en,
  output logic      [`CGC_DATA_W-1:0]    rdata,
  input  wire logic [`CGC_NUM_CLKS-1:0]  src_clk,
  output logic      [`CGC_NUM_CLKS-1:0]  gated_clk,
  output logic      [`CGC_NUM_CLKS-1:0]  gate_state
);

  // ==========================================================
  // decode helpers

  // address to register selector
  function automatic cgc_pkg::cgc_reg_type decode_addr(input logic [ADDR_W-1:0] a);
    logic [11:0] a12;
    a12 = a[11:0];
    if (a12 == `CGC_OFS_VIDEO)
      decode_addr = cgc_pkg::CGC_VIDEO;
    else if (a12 == `CGC_OFS_RSVD)
      decode_addr = cgc_pkg::CGC_RSVD;
    else if (a12 == `CGC_OFS_CORE)
      decode_addr = cgc_pkg::CGC_CORE;
    else if (a12 == `CGC_OFS_GFX)
      decode_addr = cgc_pkg::CGC_GFX;
    else if (a12 == `CGC_OFS_BUS)
      decode_addr = cgc_pkg::CGC_BUS;
    else
      decode_addr = cgc_pkg::CGC_NONE;
  endfunction

  // writable bits of each register
  function automatic logic [`CGC_HALF_W-1:0] valid_bits(input int idx);
    case (idx)
      `CGC_IDX_VIDEO: valid_bits = `CGC_VALID_VIDEO;
      `CGC_IDX_RSVD:  valid_bits = `CGC_VALID_RSVD;
      `CGC_IDX_CORE:  valid_bits = `CGC_VALID_CORE;
      `CGC_IDX_GFX:   valid_bits = `CGC_VALID_GFX;
      default: valid_bits = `CGC_VALID_BUS;
    endcase
  endfunction

  // ==========================================================
  // register file

  cgc_pkg::cgc_reg_type            wr_sel;
  cgc_pkg::cgc_reg_type            rd_sel;
  logic [`CGC_HALF_W-1:0]          wr_mask;
  logic [`CGC_HALF_W-1:0]          wr_low;
  logic [`CGC_HALF_W-1:0]          gate_q [`CGC_NUM_REGS];
  logic [`CGC_HALF_W-1:0]          gate_d [`CGC_NUM_REGS];
  logic [`CGC_DATA_W-1:0]          rdata_d;
  logic [`CGC_DATA_W-1:0]          rdata_q;

  // mask half only qualifies this write, never stored
  assign wr_sel  = decode_addr(addr);
  assign rd_sel  = decode_addr(addr);
  assign wr_mask = wdata[`CGC_MASK_HI:`CGC_MASK_LO];
  assign wr_low  = wdata[`CGC_HALF_W-1:0];

  genvar r;
  generate
    for (r = 0; r < `CGC_NUM_REGS; r++)
    begin : g_reg
      logic                   hit;
      logic [`CGC_HALF_W-1:0] m;

      // masked update of the writable bits only
      assign hit       = wr_en && (wr_sel == cgc_pkg::cgc_reg_type'(r));
      assign m         = wr_mask & valid_bits(r);
      assign gate_d[r] = hit ? ((gate_q[r] & ~m) | (wr_low & m)) : gate_q[r];

      // gate bits start at zero, all clocks run
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          gate_q[r] <= `CGC_RESET_VAL;
        else
          gate_q[r] <= gate_d[r];
      end
    end
  endgenerate

  // ==========================================================
  // readback words

  logic [`CGC_DATA_W-1:0]          rd_word [`CGC_NUM_REGS];

  genvar w;
  generate
    for (w = 0; w < `CGC_NUM_REGS; w++)
    begin : g_rd
      // mask half reads zero, reserved bits forced to zero
      assign rd_word[w] = {`CGC_HALF_W'(0), gate_q[w] & valid_bits(w)};
    end
  endgenerate

  // read data, zero outside a read and for unmapped addresses
  assign rdata_d = !rd_en                     ? `CGC_RDATA_IDLE :
                   (rd_sel == cgc_pkg::CGC_NONE) ? `CGC_RDATA_IDLE :
                   rd_word[rd_sel];

  // read data stand for the one cycle after the strobe
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata_q <= `CGC_RDATA_IDLE;
    else
      rdata_q <= rdata_d;
  end

  assign rdata = rdata_q;

  // ==========================================================
  // named gate bits

  // video bus gates
  logic                            video_dec_ahb_gate;
  logic                            video_enc_ahb_gate;
  logic                            video_proc_ahb_gate;

  // core fabric gates
  logic                            core_node_axi_gate;
  logic                            irq_ctrl_axi_gate;

  // graphics gates
  logic                            gfx_core_axi_gate;
  logic                            gfx_node_axi_gate;

  // bus interconnect node gates
  logic                            phy_node_apb_gate;
  logic                            bus_node_apb_gate;
  logic                            bus_node_ahb_gate;
  logic                            bus_node_axi_gate;

  // debug fabric and two-wire port gates
  logic                            debug_fabric_axi_gate;
  logic                            first_twowire_apb_gate;

  // fuse and crypto gates
  logic                            fuse_apb_gate;
  logic                            crypto_core_gate;
  logic                            crypto_master_gate;

  // audio gates
  logic                            digital_audio_out_ahb_gate;
  logic                            stereo_audio_port_ahb_gate;
  logic                            audio_port_b_ahb_gate;
  logic                            audio_port_a_ahb_gate;

  // memory and dma gates
  logic                            rom_ahb_gate;
  logic                            bus_dma_axi_gate;
  logic                            int_mem_axi_gate;

  // video bus register fields
  assign video_dec_ahb_gate  = gate_q[`CGC_IDX_VIDEO][`CGC_BIT_VIDEO_DEC];
  assign video_enc_ahb_gate  = gate_q[`CGC_IDX_VIDEO][`CGC_BIT_VIDEO_ENC];
  assign video_proc_ahb_gate = gate_q[`CGC_IDX_VIDEO][`CGC_BIT_VPU];

  // core fabric register fields
  assign core_node_axi_gate = gate_q[`CGC_IDX_CORE][`CGC_BIT_FABRIC0];
  assign irq_ctrl_axi_gate  = gate_q[`CGC_IDX_CORE][`CGC_BIT_FABRIC1];

  // graphics register fields
  assign gfx_core_axi_gate = gate_q[`CGC_IDX_GFX][`CGC_BIT_FABRIC0];
  assign gfx_node_axi_gate = gate_q[`CGC_IDX_GFX][`CGC_BIT_FABRIC1];

  // bus interconnect node fields
  assign phy_node_apb_gate = gate_q[`CGC_IDX_BUS][`CGC_BIT_PHY_NODE];
  assign bus_node_apb_gate = gate_q[`CGC_IDX_BUS][`CGC_BIT_APB_NODE];
  assign bus_node_ahb_gate = gate_q[`CGC_IDX_BUS][`CGC_BIT_AHB_NODE];
  assign bus_node_axi_gate = gate_q[`CGC_IDX_BUS][`CGC_BIT_AXI_NODE];

  // debug fabric and two-wire port fields
  assign debug_fabric_axi_gate  = gate_q[`CGC_IDX_BUS][`CGC_BIT_DEBUG];
  assign first_twowire_apb_gate = gate_q[`CGC_IDX_BUS][`CGC_BIT_TWOWIRE0];

  // fuse and crypto fields
  assign fuse_apb_gate      = gate_q[`CGC_IDX_BUS][`CGC_BIT_FUSE];
  assign crypto_core_gate   = gate_q[`CGC_IDX_BUS][`CGC_BIT_CRYPTO_S];
  assign crypto_master_gate = gate_q[`CGC_IDX_BUS][`CGC_BIT_CRYPTO_M];

  // audio fields
  assign digital_audio_out_ahb_gate = gate_q[`CGC_IDX_BUS][`CGC_BIT_AUDIO_OUT];
  assign stereo_audio_port_ahb_gate = gate_q[`CGC_IDX_BUS][`CGC_BIT_STEREO];
  assign audio_port_b_ahb_gate      = gate_q[`CGC_IDX_BUS][`CGC_BIT_AUDIO_B];
  assign audio_port_a_ahb_gate      = gate_q[`CGC_IDX_BUS][`CGC_BIT_AUDIO_A];

  // memory and dma fields
  assign rom_ahb_gate     = gate_q[`CGC_IDX_BUS][`CGC_BIT_ROM];
  assign bus_dma_axi_gate = gate_q[`CGC_IDX_BUS][`CGC_BIT_BUS_DMA];
  assign int_mem_axi_gate = gate_q[`CGC_IDX_BUS][`CGC_BIT_INT_MEM];

  // ==========================================================
  // gate vector

  logic [`CGC_NUM_CLKS-1:0] gate_vec;

  // video bus clocks
  assign gate_vec[`CGC_CLK_VIDEO_DEC] = video_dec_ahb_gate;
  assign gate_vec[`CGC_CLK_VIDEO_ENC] = video_enc_ahb_gate;
  assign gate_vec[`CGC_CLK_VPU]       = video_proc_ahb_gate;

  // core fabric and graphics clocks, register at 0x230 feeds none
  assign gate_vec[`CGC_CLK_CORE_NODE] = core_node_axi_gate;
  assign gate_vec[`CGC_CLK_IRQ_AXI]   = irq_ctrl_axi_gate;
  assign gate_vec[`CGC_CLK_GPU_CORE]  = gfx_core_axi_gate;
  assign gate_vec[`CGC_CLK_GPU_NODE]  = gfx_node_axi_gate;

  // bus nodes, debug fabric and two-wire port clocks
  assign gate_vec[`CGC_CLK_BUS_BASE + `CGC_BIT_PHY_NODE] = phy_node_apb_gate;
  assign gate_vec[`CGC_CLK_BUS_BASE + `CGC_BIT_APB_NODE] = bus_node_apb_gate;
  assign gate_vec[`CGC_CLK_BUS_BASE + `CGC_BIT_AHB_NODE] = bus_node_ahb_gate;
  assign gate_vec[`CGC_CLK_BUS_BASE + `CGC_BIT_AXI_NODE] = bus_node_axi_gate;
  assign gate_vec[`CGC_CLK_BUS_BASE + `CGC_BIT_DEBUG]    = debug_fabric_axi_gate;
  assign gate_vec[`CGC_CLK_BUS_BASE + `CGC_BIT_TWOWIRE0] = first_twowire_apb_gate;

  // fuse and crypto clocks
  assign gate_vec[`CGC_CLK_BUS_BASE + `CGC_BIT_FUSE]     = fuse_apb_gate;
  assign gate_vec[`CGC_CLK_BUS_BASE + `CGC_BIT_CRYPTO_S] = crypto_core_gate;
  assign gate_vec[`CGC_CLK_BUS_BASE + `CGC_BIT_CRYPTO_M] = crypto_master_gate;

  // audio clocks
  assign gate_vec[`CGC_CLK_BUS_BASE + `CGC_BIT_AUDIO_OUT] = digital_audio_out_ahb_gate;
  assign gate_vec[`CGC_CLK_BUS_BASE + `CGC_BIT_STEREO]    = stereo_audio_port_ahb_gate;
  assign gate_vec[`CGC_CLK_BUS_BASE + `CGC_BIT_AUDIO_B]   = audio_port_b_ahb_gate;
  assign gate_vec[`CGC_CLK_BUS_BASE + `CGC_BIT_AUDIO_A]   = audio_port_a_ahb_gate;

  // memory and dma clocks
  assign gate_vec[`CGC_CLK_BUS_BASE + `CGC_BIT_ROM]     = rom_ahb_gate;
  assign gate_vec[`CGC_CLK_BUS_BASE + `CGC_BIT_BUS_DMA] = bus_dma_axi_gate;
  assign gate_vec[`CGC_CLK_BUS_BASE + `CGC_BIT_INT_MEM] = int_mem_axi_gate;

  assign gate_state = gate_vec;

  // ==========================================================
  // run requests

  logic [`CGC_NUM_CLKS-1:0] run_req;

  // a clear gate bit asks for its clock to run
  assign run_req = ~gate_vec;

  // ==========================================================
  // glitch-free clock gates

  genvar c;
  generate
    for (c = 0; c < `CGC_NUM_CLKS; c++)
    begin : g_icg
      logic run_l;

      // enable follows only while source clock is low
      always_latch
      begin
        if (!src_clk[c])
          run_l <= run_req[c];
      end

      // high gate bit holds the clock low
      assign gated_clk[c] = src_clk[c] & run_l;
    end
  endgenerate

endmodule

// ===== core/cgc_defines.svh
`ifndef CGC_DEFINES_SVH
`define CGC_DEFINES_SVH

// ==========================================================
// register offsets
`define CGC_OFS_VIDEO     12'h22C
`define CGC_OFS_RSVD      12'h230
`define CGC_OFS_CORE      12'h234
`define CGC_OFS_GFX       12'h238
`define CGC_OFS_BUS       12'h23C

// ==========================================================
// register layout
`define CGC_NUM_REGS      5
`define CGC_HALF_W        16
`define CGC_DATA_W        32
`define CGC_MASK_HI       31
`define CGC_MASK_LO       16
`define CGC_RESET_VAL     16'h0000
`define CGC_RDATA_IDLE    32'h0000_0000

// ==========================================================
// gate bits that exist in each register, others reserved
`define CGC_VALID_VIDEO   16'h0111
`define CGC_VALID_RSVD    16'h0000
`define CGC_VALID_CORE    16'h0003
`define CGC_VALID_GFX     16'h0003
`define CGC_VALID_BUS     16'hFFFF

// ==========================================================
// register index in the gate array
`define CGC_IDX_VIDEO     0
`define CGC_IDX_RSVD      1
`define CGC_IDX_CORE      2
`define CGC_IDX_GFX       3
`define CGC_IDX_BUS       4

// ==========================================================
// bit positions in the bus peripheral register
`define CGC_BIT_PHY_NODE  15
`define CGC_BIT_APB_NODE  14
`define CGC_BIT_AHB_NODE  13
`define CGC_BIT_AXI_NODE  12
`define CGC_BIT_DEBUG     11
`define CGC_BIT_TWOWIRE0  10
`define CGC_BIT_FUSE      9
`define CGC_BIT_CRYPTO_S  8
`define CGC_BIT_CRYPTO_M  7
`define CGC_BIT_AUDIO_OUT 6
`define CGC_BIT_STEREO    5
`define CGC_BIT_AUDIO_B   4
`define CGC_BIT_AUDIO_A   3
`define CGC_BIT_ROM       2
`define CGC_BIT_BUS_DMA   1
`define CGC_BIT_INT_MEM   0

// ==========================================================
// bit positions of gates
`define CGC_BIT_VIDEO_DEC 0
`define CGC_BIT_VIDEO_ENC 4
`define CGC_BIT_VPU       8
`define CGC_BIT_FABRIC0   0
`define CGC_BIT_FABRIC1   1

// ==========================================================
// positions in the gated clock vector
`define CGC_NUM_CLKS      23
`define CGC_CLK_VIDEO_DEC 0
`define CGC_CLK_VIDEO_ENC 1
`define CGC_CLK_VPU       2
`define CGC_CLK_CORE_NODE 3
`define CGC_CLK_IRQ_AXI   4
`define CGC_CLK_GPU_CORE  5
`define CGC_CLK_GPU_NODE  6
`define CGC_CLK_BUS_BASE  7

`endif

// ===== core/cgc_pkg.sv
package cgc_pkg;

  // ==========================================================
  // register selector
  typedef enum logic [2:0]
  {
    CGC_VIDEO = 3'b000,
    CGC_RSVD  = 3'b001,
    CGC_CORE  = 3'b010,
    CGC_GFX   = 3'b011,
    CGC_BUS   = 3'b100,
    CGC_NONE  = 3'b111
  } cgc_reg_type;

endpackage

// ===== testbench/cgc_gate_checker.sv
`timescale 1ns/1ps
`include "cgc_defines.svh"
module cgc_gate_checker #(
  parameter int ADDR_W = 12
)(
  input wire logic                     clk,
  input wire logic                     rstn,
  input wire logic [ADDR_W-1:0]        addr,
  input wire logic [31:0]              wdata,
  input wire logic                     wr_en,
  input wire logic                     rd_en,
  input wire logic [31:0]              rdata,
  input wire logic [`CGC_NUM_CLKS-1:0] src_clk,
  input wire logic [`CGC_NUM_CLKS-1:0] gated_clk,
  input wire logic [`CGC_NUM_CLKS-1:0] gate_state
);
  // ==========================================================
  // previous cycle copies
  logic [15:0]              mk_q;
  logic [15:0]              dv_q;
  logic [`CGC_NUM_CLKS-1:0] gs_q;
  wire  [15:0]              nb = (mk_q & dv_q) | (~mk_q & gs_q[22:7]);
  wire  [1:0]               nc = (mk_q[1:0] & dv_q[1:0]) | (~mk_q[1:0] & gs_q[4:3]);
  wire  [1:0]               ng = (mk_q[1:0] & dv_q[1:0]) | (~mk_q[1:0] & gs_q[6:5]);
  wire                      same = (gate_state == gs_q);
  // capture bus data and gate state
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mk_q <= 16'h0000;
      dv_q <= 16'h0000;
      gs_q <= '0;
    end
    else
    begin
      mk_q <= wdata[31:16];
      dv_q <= wdata[15:0];
      gs_q <= gate_state;
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 32'h0)
    else $error("rdata not zero outside read");
  a_bus_write: assert property (wr_en && addr == 'h23C |=> gate_state[22:7] == nb)
    else $error("bus gate write wrong");
  a_core_write: assert property (wr_en && addr == 'h234 |=> gate_state[4:3] == nc)
    else $error("core gate write wrong");
  a_gfx_write: assert property (wr_en && addr == 'h238 |=> gate_state[6:5] == ng)
    else $error("graphics gate write wrong");
  a_read_bus: assert property (rd_en && addr == 'h23C |=> rdata == {16'h0, gs_q[22:7]})
    else $error("bus gate read wrong");
  a_read_rsvd: assert property (rd_en && addr == 'h230 |=> rdata == 32'h0)
    else $error("reserved register read not zero");
  a_gate_stop: assert property (same |-> (gated_clk & gate_state) == '0)
    else $error("stopped clock still running");
  a_gate_run: assert property (same |-> (gated_clk & ~gate_state) == (src_clk & ~gate_state))
    else $error("running clock not passed");
  c_bus_write: cover property (wr_en && addr == 'h23C);
  c_rsvd_write: cover property (wr_en && addr == 'h230);
  c_bus_read: cover property (rd_en && addr == 'h23C);
endmodule
bind cgc_gate_regs cgc_gate_checker #(.ADDR_W(ADDR_W)) u_chk (.clk, .rstn, .addr, .wdata,
  .wr_en, .rd_en, .rdata, .src_clk, .gated_clk, .gate_state);

// ===== testbench/cgc_gate_regs_test.sv
`timescale 1ns/1ps
module cgc_gate_regs_test;
  logic        clk, rstn, wr_en, rd_en;
  logic [11:0] addr;
  logic [31:0] wdata, rdata;
  logic [22:0] src_clk, gated_clk, gate_state;
  int          n_fail, checks_done;
  logic [11:0] ofs [5] = '{12'h22C, 12'h230, 12'h234, 12'h238, 12'h23C};
  logic [31:0] vm [5] = '{32'h111, 32'h0, 32'h3, 32'h3, 32'hFFFF};
  cgc_gate_regs u_dut (.clk, .rstn, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .src_clk, .gated_clk, .gate_state);
  // ==========================================================
  // clocks, source clocks off the register clock edges
  always #25 clk = ~clk;
  initial
  begin
    src_clk = '0;
    #19;
    forever #5 src_clk = ~src_clk;
  end
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 cmp(rdata, e);
  endtask
  task test_done;
    $display("checks %0d fail %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    clk = 0; rstn = 0; addr = 0; wdata = 0; wr_en = 0; rd_en = 0; n_fail = 0; checks_done = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++) rd(ofs[i], 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      wr(ofs[i], 32'hFFFF_FFFF);
      rd(ofs[i], vm[i]);
    end
    cmp({9'h0, gate_state}, 32'h007F_FFFF);
    @(posedge clk);
    #2 cmp({9'h0, gated_clk}, 32'h0);
    wr(12'h23C, 32'h0005_0000);
    rd(12'h23C, 32'h0000_FFFA);
    wr(12'h23C, 32'h0000_FFFF);
    rd(12'h23C, 32'h0000_FFFA);
    wr(12'h22C, 32'h0110_0000);
    rd(12'h22C, 32'h0000_0001);
    wr(12'h240, 32'hFFFF_FFFF);
    rd(12'h240, 32'h0);
    cmp({9'h0, gate_state}, 32'h007F_FD79);
    @(posedge clk);
    #2 cmp({9'h0, gated_clk}, 32'h0000_0286);
    test_done;
  end
  // hang guard
  initial
  begin
    #200000;
    n_fail++;
    test_done;
  end
endmodule
